// File: logic/slwd_pkg.sv
// shared constants and types for the self-test, level and watchdog registers
package slwd_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_SELF_TEST_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h15;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h16;

  // values after reset
  localparam logic [2:0] RST_SELF_TEST = 3'h0;
  localparam logic RST_LEVEL = 1'h1;
  localparam logic [7:0] RST_WATCHDOG = 8'hfe;

  // field positions
  localparam int ST_EN_BIT = 0;
  localparam int ST_SRC_LSB = 1;
  localparam int ST_SRC_MSB = 2;
  localparam int WD_DIS_BIT = 0;
  localparam int WD_TIME_LSB = 1;
  localparam int WD_TIME_MSB = 7;

  // keyed write values for the level setting
  localparam logic [7:0] LEVEL_KEY_SET = 8'hb5;
  localparam logic [7:0] LEVEL_KEY_CLEAR = 8'hb6;

  // level setting encoding: 1 means 3.3 V, 0 means 1.8 V
  localparam logic LEVEL_3V3 = 1'h1;
  localparam logic LEVEL_1V8 = 1'h0;

  // fallback clock source field codes
  localparam logic [1:0] SRC_00 = 2'h0;
  localparam logic [1:0] SRC_01 = 2'h1;
  localparam logic [1:0] SRC_10 = 2'h2;
  localparam logic [1:0] SRC_11 = 2'h3;

  // watchdog step time and system clock rate
  localparam int unsigned WD_STEP_MS = 2;
  localparam int unsigned CLK_SYS_MHZ = 250;
  localparam int unsigned WD_STEP_CYCLES = WD_STEP_MS * CLK_SYS_MHZ * 1000;

  // the clock that the frame logic is told to run on
  typedef enum logic [2:0] {
    SLWD_CLK_NONE,
    SLWD_CLK_PIXEL,
    SLWD_CLK_OSC25,
    SLWD_CLK_OSC33,
    SLWD_CLK_OSC50,
    SLWD_CLK_OSC100
  } slwd_clk_t;

  // watchdog states
  typedef enum logic [1:0] {
    SLWD_WD_IDLE,
    SLWD_WD_RUN
  } slwd_wd_state_t;

endpackage

// File: logic/slwd_regs.sv
// self-test, control-pin level and control-channel watchdog registers
`timescale 1ns/10ps
module slwd_regs #(
  parameter int unsigned WD_STEP_CYCLES = slwd_pkg::WD_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // power-up strap and digital resets
  input wire logic level_strap_pin,
  input wire logic digital_reset_a,
  input wire logic digital_reset_b,
  // clock selection inputs from the rest of the device
  input wire logic video_clk_present,
  input wire logic fallback_enable,
  // clock selection and mode outputs
  output logic self_test_mode,
  output slwd_pkg::slwd_clk_t clk_choice,
  output logic control_port_level_sel,
  // control channel transaction tracking
  input wire logic chan_txn_start,
  input wire logic chan_txn_done,
  output logic chan_wd_abort,
  output logic chan_wd_busy
);

  // stored register contents
  logic [2:0] self_test_ctrl;
  logic [7:0] wd_ctrl;
  logic level_val;
  logic strap_taken;

  // decoded strobes
  logic wr_self_test;
  logic wr_level;
  logic wr_wd;
  logic digital_reset;

  // derived fields
  logic st_enable;
  logic [1:0] src_field;
  logic [6:0] wd_timeout;
  logic wd_disable;

  // watchdog datapath
  slwd_pkg::slwd_wd_state_t wd_state;
  slwd_pkg::slwd_wd_state_t next_wd_state;
  logic [6:0] step_count;
  logic [6:0] next_step_count;
  logic step_tick;
  logic tick_restart;
  logic expire;
  slwd_pkg::slwd_clk_t next_clk_choice;

  // write decode; any address outside the three is silently ignored
  assign wr_self_test = reg_wr && (reg_addr == slwd_pkg::ADDR_SELF_TEST_CONTROL);
  assign wr_level = reg_wr && (reg_addr == slwd_pkg::ADDR_LEVEL_SELECT);
  assign wr_wd = reg_wr && (reg_addr == slwd_pkg::ADDR_WATCHDOG_CONTROL);
  assign digital_reset = digital_reset_a || digital_reset_b;

  // field views of the stored registers
  assign st_enable = self_test_ctrl[slwd_pkg::ST_EN_BIT];
  assign src_field = self_test_ctrl[slwd_pkg::ST_SRC_MSB:slwd_pkg::ST_SRC_LSB];
  assign wd_timeout = wd_ctrl[slwd_pkg::WD_TIME_MSB:slwd_pkg::WD_TIME_LSB];
  assign wd_disable = wd_ctrl[slwd_pkg::WD_DIS_BIT];

  // self-test control: bits 7:3 are reserved, not stored, read as zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      self_test_ctrl <= slwd_pkg::RST_SELF_TEST;
    end else if (wr_self_test) begin
      self_test_ctrl <= reg_wdata[2:0];
    end
  end

  // strap capture happens in the first clocked cycle after reset release,
  // since an asynchronous reset may only load a constant
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // level setting: strap first, then digital resets win over keyed writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      level_val <= slwd_pkg::RST_LEVEL;
    end else if (!strap_taken) begin
      // low strap selects 3.3 V, high strap 1.8 V
      level_val <= level_strap_pin ? slwd_pkg::LEVEL_1V8
                                   : slwd_pkg::LEVEL_3V3;
    end else if (digital_reset) begin
      level_val <= slwd_pkg::LEVEL_3V3;
    end else if (wr_level && (reg_wdata == slwd_pkg::LEVEL_KEY_SET)) begin
      level_val <= slwd_pkg::LEVEL_3V3;
    end else if (wr_level && (reg_wdata == slwd_pkg::LEVEL_KEY_CLEAR)) begin
      level_val <= slwd_pkg::LEVEL_1V8;
    end
  end

  // watchdog control register, full eight bits stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_ctrl <= slwd_pkg::RST_WATCHDOG;
    end else if (wr_wd) begin
      wd_ctrl <= reg_wdata;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        slwd_pkg::ADDR_SELF_TEST_CONTROL: begin
          reg_rdata <= {5'h00, self_test_ctrl};
        end
        slwd_pkg::ADDR_LEVEL_SELECT: begin
          reg_rdata <= {7'h00, level_val};
        end
        slwd_pkg::ADDR_WATCHDOG_CONTROL: begin
          reg_rdata <= wd_ctrl;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // clock source decode; self-test takes priority over the functional
  // fallback, and a present video clock needs no fallback at all
  always_comb begin
    next_clk_choice = slwd_pkg::SLWD_CLK_NONE;
    if (st_enable) begin
      case (src_field)
        slwd_pkg::SRC_00: begin
          next_clk_choice = slwd_pkg::SLWD_CLK_PIXEL;
        end
        slwd_pkg::SRC_01: begin
          next_clk_choice = slwd_pkg::SLWD_CLK_OSC33;
        end
        default: begin
          next_clk_choice = slwd_pkg::SLWD_CLK_OSC100;
        end
      endcase
    end else if (!video_clk_present && fallback_enable) begin
      case (src_field)
        slwd_pkg::SRC_10: begin
          next_clk_choice = slwd_pkg::SLWD_CLK_OSC100;
        end
        slwd_pkg::SRC_11: begin
          next_clk_choice = slwd_pkg::SLWD_CLK_OSC25;
        end
        default: begin
          next_clk_choice = slwd_pkg::SLWD_CLK_OSC50;
        end
      endcase
    end
  end

  // registered so the clock mux sees a clean, glitch-free selection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_choice <= slwd_pkg::SLWD_CLK_NONE;
    end else begin
      clk_choice <= next_clk_choice;
    end
  end

  // mode and level outputs follow the stored bits, one flop late
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      self_test_mode <= 1'b0;
      control_port_level_sel <= slwd_pkg::RST_LEVEL;
    end else begin
      self_test_mode <= st_enable;
      control_port_level_sel <= level_val;
    end
  end

  // a new start re-arms the step timer so the first step is a full 2 ms
  assign tick_restart = chan_txn_start;

  slwd_tick #(
    .PERIOD(WD_STEP_CYCLES)
  ) u_step (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(wd_state == slwd_pkg::SLWD_WD_RUN),
    .restart(tick_restart),
    .tick(step_tick)
  );

  // timeout is reached when the step count meets the field; a zero field
  // would expire on the first step, which software must avoid
  assign expire = step_tick &&
                  ((step_count + 7'h01) >= wd_timeout);

  // watchdog sequencing: completion beats expiry in the same cycle
  always_comb begin
    next_wd_state = wd_state;
    next_step_count = step_count;
    case (wd_state)
      slwd_pkg::SLWD_WD_IDLE: begin
        next_step_count = 7'h00;
        if (chan_txn_start && !wd_disable) begin
          next_wd_state = slwd_pkg::SLWD_WD_RUN;
        end
      end
      slwd_pkg::SLWD_WD_RUN: begin
        if (wd_disable) begin
          next_wd_state = slwd_pkg::SLWD_WD_IDLE;
          next_step_count = 7'h00;
        end else if (chan_txn_start) begin
          next_step_count = 7'h00;
        end else if (chan_txn_done) begin
          next_wd_state = slwd_pkg::SLWD_WD_IDLE;
          next_step_count = 7'h00;
        end else if (expire) begin
          next_wd_state = slwd_pkg::SLWD_WD_IDLE;
          next_step_count = 7'h00;
        end else if (step_tick) begin
          next_step_count = step_count + 7'h01;
        end
      end
      default: begin
        next_wd_state = slwd_pkg::SLWD_WD_IDLE;
        next_step_count = 7'h00;
      end
    endcase
  end

  // watchdog state and step count
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wd_state <= slwd_pkg::SLWD_WD_IDLE;
      step_count <= 7'h00;
    end else begin
      wd_state <= next_wd_state;
      step_count <= next_step_count;
    end
  end

  // abort pulse: one cycle, only for a running, enabled, stalled transaction
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chan_wd_abort <= 1'b0;
    end else begin
      chan_wd_abort <= (wd_state == slwd_pkg::SLWD_WD_RUN) && !wd_disable &&
                       !chan_txn_start && !chan_txn_done && expire;
    end
  end

  // busy shows that a transaction is being timed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chan_wd_busy <= 1'b0;
    end else begin
      chan_wd_busy <= (next_wd_state == slwd_pkg::SLWD_WD_RUN);
    end
  end

endmodule

// File: logic/slwd_tick.sv
// step timer: one-cycle tick every PERIOD cycles, restartable
`timescale 1ns/10ps
module slwd_tick #(
  parameter int unsigned PERIOD = 500000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic restart,
  // result
  output logic tick
);

  localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt;

  // the count only advances while a transaction is being timed, so an idle
  // watchdog burns no toggles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (restart || !run) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  // tick stands for the single cycle in which the step ends
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && !restart && (cnt == LAST);
    end
  end

endmodule

// File: tb/slwd_regs_properties.sv
// checker for the slwd_regs register, clock choice and watchdog ports
`timescale 1ns/10ps
module slwd_regs_properties #(
  parameter int unsigned WD_STEP_CYCLES = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // resets and clock selection
  input wire logic digital_reset_a,
  input wire logic digital_reset_b,
  input wire logic video_clk_present,
  input wire logic fallback_enable,
  input wire logic self_test_mode,
  input wire slwd_pkg::slwd_clk_t clk_choice,
  input wire logic control_port_level_sel,
  // watchdog
  input wire logic chan_txn_start,
  input wire logic chan_txn_done,
  input wire logic chan_wd_abort,
  input wire logic chan_wd_busy
);
  localparam int BUSY_MAX = 127 * WD_STEP_CYCLES + 4;
  logic [15:0] busy_len;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // length of the current timed run; a new start restarts it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_len <= 16'h0000;
    end else if (!chan_wd_busy || chan_txn_start) begin
      busy_len <= 16'h0000;
    end else begin
      busy_len <= busy_len + 16'h0001;
    end
  end

  // a write to one register not followed by another to the same one
  sequence st_write;
    reg_wr && reg_addr == slwd_pkg::ADDR_SELF_TEST_CONTROL
    ##1 !(reg_wr && reg_addr == slwd_pkg::ADDR_SELF_TEST_CONTROL);
  endsequence
  sequence key_write;
    reg_wr && reg_addr == slwd_pkg::ADDR_LEVEL_SELECT
    && reg_wdata inside {8'hb5, 8'hb6} && !digital_reset_a
    && !digital_reset_b ##1 !digital_reset_a && !digital_reset_b
    && !(reg_wr && reg_addr == slwd_pkg::ADDR_LEVEL_SELECT);
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  st_follow_a: assert property (st_write |=>
    self_test_mode == $past(reg_wdata[0], 2))
    else $error("self test mode does not follow its bit");
  key_level_a: assert property (key_write |=>
    control_port_level_sel == $past(reg_wdata[0], 2))
    else $error("keyed write did not move the level");
  dreset_level_a: assert property (digital_reset_a || digital_reset_b
    |-> ##2 control_port_level_sel)
    else $error("digital reset did not force 3.3 V");
  clk_none_a: assert property (!self_test_mode &&
    ($past(video_clk_present) || !$past(fallback_enable))
    |-> clk_choice == slwd_pkg::SLWD_CLK_NONE)
    else $error("clock chosen without cause");
  clk_test_a: assert property (self_test_mode |-> clk_choice inside
    {slwd_pkg::SLWD_CLK_PIXEL, slwd_pkg::SLWD_CLK_OSC33,
     slwd_pkg::SLWD_CLK_OSC100})
    else $error("bad self test clock");
  clk_fallback_a: assert property ($past(nrst) && !self_test_mode
    && !$past(video_clk_present) && $past(fallback_enable)
    |-> clk_choice inside {slwd_pkg::SLWD_CLK_OSC50,
    slwd_pkg::SLWD_CLK_OSC100, slwd_pkg::SLWD_CLK_OSC25})
    else $error("bad fallback clock");
  abort_pulse_a: assert property (chan_wd_abort |-> $past(chan_wd_busy)
    && !chan_wd_busy ##1 !chan_wd_abort)
    else $error("abort not a single pulse ending a run");
  done_stop_a: assert property (chan_txn_done && !chan_txn_start
    |=> !chan_wd_busy && !chan_wd_abort)
    else $error("completion did not stop the watchdog");
  busy_bound_a: assert property (busy_len <= BUSY_MAX)
    else $error("transaction outlived the longest timeout");
endmodule

bind slwd_regs slwd_regs_properties #(.WD_STEP_CYCLES(WD_STEP_CYCLES))
  i_slwd_regs_properties (.*);

// File: tb/testbench.sv
// self-checking bench for the slwd_regs register block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic level_strap_pin = 1'b1;
  logic digital_reset_a = 1'b0;
  logic digital_reset_b = 1'b0;
  logic video_clk_present = 1'b1;
  logic fallback_enable = 1'b0;
  logic self_test_mode;
  slwd_pkg::slwd_clk_t clk_choice;
  logic control_port_level_sel;
  logic chan_txn_start = 1'b0;
  logic chan_txn_done = 1'b0;
  logic chan_wd_abort;
  logic chan_wd_busy;
  int n_errors = 0;
  int checked = 0;
  int seed = 32'hb918;
  int n;
  logic [7:0] v;

  // short step so a whole timeout fits in a few hundred cycles
  slwd_regs #(.WD_STEP_CYCLES(4)) i_slwd_regs (.*);

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  // expected clock choice from mode, source field and inputs
  function automatic slwd_pkg::slwd_clk_t exp_clk(logic st, logic [1:0] s,
      logic vid, logic fb);
    if (st) return s == 2'h0 ? slwd_pkg::SLWD_CLK_PIXEL :
      s == 2'h1 ? slwd_pkg::SLWD_CLK_OSC33 : slwd_pkg::SLWD_CLK_OSC100;
    if (vid || !fb) return slwd_pkg::SLWD_CLK_NONE;
    return s == 2'h2 ? slwd_pkg::SLWD_CLK_OSC100 :
      s == 2'h3 ? slwd_pkg::SLWD_CLK_OSC25 : slwd_pkg::SLWD_CLK_OSC50;
  endfunction

  // one-cycle register write and read
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // data stand for one cycle; take them mid-cycle, leave on an edge
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  // strap held through reset and past the capturing edge
  task automatic reset_dut(logic strap);
    nrst <= 1'b0;
    level_strap_pin <= strap;
    repeat (20) @(posedge clk_sys);
    `CHK("lvl_in_rst", 1'b1, control_port_level_sel)
    `CHK("clk_in_rst", slwd_pkg::SLWD_CLK_NONE, clk_choice)
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // one-cycle start or completion pulse
  task automatic pulse(logic done);
    @(posedge clk_sys);
    chan_txn_start <= !done;
    chan_txn_done <= done;
    @(posedge clk_sys);
    chan_txn_start <= 1'b0;
    chan_txn_done <= 1'b0;
  endtask

  // cycles until abort, bounded so a silent watchdog cannot hang us
  task automatic wait_abort(int lim);
    n = 0;
    @(negedge clk_sys);
    while (chan_wd_abort !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #100000;
    n_errors++;
    print_verdict;
  end

  // main sequence
  initial begin
    reset_dut(1'b1);
    `CHK("lvl_strap", 1'b0, control_port_level_sel)
    rd(8'h15, v);
    `CHK("lvl_rd", 8'h00, v)
    rd(8'h14, v);
    `CHK("st_rst", 8'h00, v)
    wr(8'h17, 8'hff);
    rd(8'h17, v);
    `CHK("unmapped", 8'h00, v)
    // every enable, source, video and fallback combination
    for (int i = 0; i < 32; i++) begin
      v = $random(seed);
      video_clk_present <= i[3];
      fallback_enable <= i[4];
      wr(8'h14, {v[7:3], i[2:0]});
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("st_mode", i[0], self_test_mode)
      `CHK("clk", exp_clk(i[0], i[2:1], i[3], i[4]), clk_choice)
      rd(8'h14, v);
      `CHK("st_rd", {5'h00, i[2:0]}, v)
    end
    wr(8'h15, 8'hb5);
    v = $random(seed);
    wr(8'h15, (v inside {8'hb5, 8'hb6}) ? 8'h00 : v);
    rd(8'h15, v);
    `CHK("key_set", 8'h01, v)
    wr(8'h15, 8'hb6);
    rd(8'h15, v);
    `CHK("key_clr", 8'h00, v)
    `CHK("lvl_pin", 1'b0, control_port_level_sel)
    // reset beside a clearing key wins
    digital_reset_a <= 1'b1;
    wr(8'h15, 8'hb6);
    digital_reset_a <= 1'b0;
    rd(8'h15, v);
    `CHK("dreset_a", 8'h01, v)
    wr(8'h15, 8'hb6);
    @(posedge clk_sys);
    digital_reset_b <= 1'b1;
    @(posedge clk_sys);
    digital_reset_b <= 1'b0;
    rd(8'h15, v);
    `CHK("dreset_b", 8'h01, v)
    rd(8'h16, v);
    `CHK("wd_rst", 8'hfe, v)
    wr(8'h16, 8'h02);
    pulse(1'b0);
    wait_abort(2000);
    `CHK("wd_t1", 1'b1, n >= 4 && n <= 8)
    // a second start restarts the count
    wr(8'h16, 8'h06);
    pulse(1'b0);
    repeat (5) @(posedge clk_sys);
    pulse(1'b0);
    wait_abort(2000);
    `CHK("wd_t3", 1'b1, n >= 12 && n <= 16)
    pulse(1'b0);
    @(negedge clk_sys);
    `CHK("wd_busy", 1'b1, chan_wd_busy)
    pulse(1'b1);
    wait_abort(40);
    `CHK("wd_done", 40, n)
    // disabling a running watchdog stops it with no abort
    wr(8'h16, 8'h02);
    pulse(1'b0);
    wr(8'h16, 8'h03);
    wait_abort(40);
    `CHK("wd_stop", 40, n)
    `CHK("wd_stop_busy", 1'b0, chan_wd_busy)
    pulse(1'b0);
    wait_abort(40);
    `CHK("wd_off", 40, n)
    `CHK("wd_off_busy", 1'b0, chan_wd_busy)
    reset_dut(1'b0);
    rd(8'h15, v);
    `CHK("lvl_strap_lo", 8'h01, v)
    print_verdict;
  end
endmodule
